// ===== rtl/tcf_capture.sv
`timescale 1ns/1ns
`include "tcf_map.svh"

// Operation
// - in debug mode one of four capture modes is selected before capture begins.
// - normal mode uses comparators A and B as trigger sources.
// - normal mode stores flow or data words according to the trigger-mode field.
// - loop mode loads each stored address into comparator C and sets it to ignore mode.
// - loop mode does not store a source address that matches comparator C.
// - setting arm in loop mode clears comparator C.
// - loop mode never raises a breakpoint from a comparator C match.
// - loop mode filters only source addresses, never destination or vector addresses.
// - a source refetched in the cycle after it is stored is already suppressed, as comparator C updates at the store.
// - duplicate detection uses the logical address only and ignores paging.
module tcf_capture
  import tcf_pkg::*;
#(
  parameter int AW = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // configuration
  input wire logic debugEnable,
  input wire logic arm,
  input wire logic [1:0] captureMode,
  input wire logic triggerModeField,
  input wire logic [AW-1:0] cmpA,
  input wire logic [AW-1:0] cmpB,
  input wire logic cmpCBreakEnable,
  input wire logic [AW-1:0] cmpCUser,
  // observed bus activity
  input wire tcf_pkg::tcf_bus_ev_t busEv,
  input wire logic [7:0] busPage,
  // trace output
  output tcf_pkg::tcf_trace_wr_t traceWr,
  output logic triggered,
  output logic cmpCBreak,
  output logic [15:0] suppressCount,
  output logic [15:0] otherModeCount
);
  import tcf_pkg::*;

  // trace words and comparators are fixed at 16 bits
  if (AW != 16)
  begin : g_aw_check
    $error("tcf_capture: AW must be 16");
  end

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TCF_ST_IDLE = 3'b001,
    TCF_ST_ARMED = 3'b010,
    TCF_ST_RUN = 3'b100
  } tcf_state_t;

  tcf_state_t state_q;
  tcf_state_t state_d;
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic trgSel_q;
  logic trgSel_d;
  logic arm_q;
  logic armRise;
  logic [1:0] trigHit;
  logic cHit;
  logic cLoad;
  logic cClear;
  logic loopMode;
  logic storeNow;
  logic [15:0] storeWord;
  logic wantKind;
  tcf_trace_wr_t traceWr_q;
  tcf_trace_wr_t traceWr_d;
  logic triggered_q;
  logic triggered_d;
  logic cmpCBreak_q;
  logic cmpCBreak_d;
  logic [15:0] supp_q;
  logic [15:0] supp_d;
  logic [15:0] oth_q;
  logic [15:0] oth_d;

  // arm edge, logic on the same clock
  assign armRise = arm && !arm_q;
  assign loopMode = (mode_q == `TCF_MODE_LOOP);

  // trigger comparators A and B
  tcf_trig_cmp #(
    .AW(AW)
  ) u_trig (
    .enable(mode_q == `TCF_MODE_NORMAL),
    .ref0(cmpA),
    .ref1(cmpB),
    .probe(busEv.addr),
    .hit(trigHit)
  );

  // comparator C, reloaded in loop mode
  tcf_addr_cmp #(
    .AW(AW)
  ) u_cmpc (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(cLoad),
    .loadAddr(armRise ? cmpCUser : traceWr_d.word),
    .clear(cClear),
    .probe(busEv.addr), // logical address only, page ignored
    .valid(),
    .hit(cHit)
  );

  // arm in loop mode empties comparator C
  assign cClear = armRise && (mode_d == `TCF_MODE_LOOP);
  // ----------------------------------------------------------------
  // capture decision
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    mode_d = mode_q;
    trgSel_d = trgSel_q;
    triggered_d = triggered_q;
    storeNow = 1'b0;
    storeWord = busEv.addr;
    wantKind = 1'b0;
    supp_d = supp_q;
    oth_d = oth_q;
    cmpCBreak_d = 1'b0;
    // mode and field latched at arm, before capture
    if (armRise && debugEnable)
    begin
      mode_d = captureMode;
      trgSel_d = triggerModeField;
      triggered_d = 1'b0;
      state_d = TCF_ST_ARMED;
    end
    else if (!arm || !debugEnable)
    begin
      state_d = TCF_ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        TCF_ST_IDLE:
        begin
          state_d = TCF_ST_IDLE;
        end
        TCF_ST_ARMED:
        begin
          if (mode_q != `TCF_MODE_NORMAL)
            state_d = TCF_ST_RUN;
          else if (busEv.valid && (|trigHit))
          begin
            triggered_d = 1'b1;
            state_d = TCF_ST_RUN;
          end
        end
        TCF_ST_RUN:
        begin
          state_d = TCF_ST_RUN;
        end
        default:
        begin
          state_d = TCF_ST_IDLE;
        end
      endcase
    end
    // choose what an event stores
    if (state_q == TCF_ST_RUN && busEv.valid)
    begin
      unique case (mode_q)
        `TCF_MODE_NORMAL:
        begin
          // flow or data words by trigger-mode field
          wantKind = (trgSel_q == `TCF_TRG_DATA) ? (busEv.kind == TCF_EV_DATA) : (busEv.kind != TCF_EV_DATA);
          storeNow = wantKind;
          storeWord = (busEv.kind == TCF_EV_DATA) ? busEv.data : busEv.addr;
        end
        `TCF_MODE_LOOP:
        begin
          // only source addresses are filtered
          if (busEv.kind == TCF_EV_DATA)
            storeNow = 1'b0;
          else if (busEv.kind == TCF_EV_SRC && cHit)
          begin
            storeNow = 1'b0;
            supp_d = supp_q + 16'h0001;
          end
          else
            storeNow = 1'b1;
        end
        default:
        begin
          oth_d = oth_q + 16'h0001;
        end
      endcase
    end
    // comparator C breakpoint only outside loop mode
    if (!loopMode && cmpCBreakEnable && busEv.valid && cHit && state_q == TCF_ST_RUN)
      cmpCBreak_d = 1'b1;
    traceWr_d.valid = storeNow;
    traceWr_d.kind = busEv.kind;
    traceWr_d.word = storeWord;
  end

  // copy stored address into C in the write cycle; a refetch seen
  // the next cycle is already suppressed
  // user value at any arm into a non-loop mode, so no stale loop address breaks
  assign cLoad = (loopMode && storeNow && busEv.kind != TCF_EV_DATA)
    || (armRise && debugEnable && mode_d != `TCF_MODE_LOOP);

  // registers
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q <= TCF_ST_IDLE;
      mode_q <= `TCF_MODE_NORMAL;
      trgSel_q <= `TCF_TRG_FLOW;
      arm_q <= 1'b0;
      traceWr_q <= '0;
      triggered_q <= 1'b0;
      cmpCBreak_q <= 1'b0;
      supp_q <= `TCF_CNT_RST;
      oth_q <= `TCF_CNT_RST;
    end
    else
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      trgSel_q <= trgSel_d;
      arm_q <= arm;
      traceWr_q <= traceWr_d; // in order of occurrence
      triggered_q <= triggered_d;
      cmpCBreak_q <= cmpCBreak_d;
      supp_q <= supp_d;
      oth_q <= oth_d;
    end
  end

  assign traceWr = traceWr_q;
  assign triggered = triggered_q;
  assign cmpCBreak = cmpCBreak_q;
  assign suppressCount = supp_q;
  assign otherModeCount = oth_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic lastSrcValid_q;
  logic [15:0] lastSrc_q;
  always_ff @(posedge clk_sys)
  begin
    if (srst || cClear)
      lastSrcValid_q <= 1'b0;
    else if (loopMode && traceWr_d.valid)
    begin
      lastSrcValid_q <= 1'b1;
      lastSrc_q <= traceWr_d.word;
    end
  end

  property p_loop_nobreak;
    @(posedge clk_sys) disable iff (srst)
    loopMode |=> !cmpCBreak;
  endproperty
  a_loop_nobreak: assert property (p_loop_nobreak) else $error("break from C in loop mode");

  property p_loop_dup;
    @(posedge clk_sys) disable iff (srst)
    (loopMode && state_q == TCF_ST_RUN && arm && debugEnable && busEv.valid && busEv.kind == TCF_EV_SRC
      && lastSrcValid_q && busEv.addr == lastSrc_q) |=> !traceWr.valid;
  endproperty
  a_loop_dup: assert property (p_loop_dup) else $error("duplicate source stored");

  property p_loop_dst;
    @(posedge clk_sys) disable iff (srst)
    (loopMode && state_q == TCF_ST_RUN && busEv.valid && busEv.kind inside {TCF_EV_DST, TCF_EV_VEC})
      |=> traceWr.valid && traceWr.word == $past(busEv.addr);
  endproperty
  a_loop_dst: assert property (p_loop_dst) else $error("destination or vector dropped");

  property p_arm_clear;
    @(posedge clk_sys) disable iff (srst)
    (armRise && debugEnable && captureMode == `TCF_MODE_LOOP) |=> !cHit;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("C not cleared on arm");

  property p_norm_data;
    @(posedge clk_sys) disable iff (srst)
    (traceWr.valid && mode_q == `TCF_MODE_NORMAL && trgSel_q == `TCF_TRG_DATA) |-> traceWr.kind == TCF_EV_DATA;
  endproperty
  a_norm_data: assert property (p_norm_data) else $error("flow stored in data mode");

  property p_norm_trig;
    @(posedge clk_sys) disable iff (srst)
    (mode_q == `TCF_MODE_NORMAL && state_q == TCF_ST_ARMED && arm && debugEnable && !armRise
      && busEv.valid && (busEv.addr == cmpA || busEv.addr == cmpB)) |=> triggered ##0 state_q == TCF_ST_RUN;
  endproperty
  a_norm_trig: assert property (p_norm_trig) else $error("A/B match did not trigger");

  property p_mode_latch;
    @(posedge clk_sys) disable iff (srst)
    (armRise && debugEnable) |=> mode_q == $past(captureMode);
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode not taken at arm");

  property p_loop_load;
    @(posedge clk_sys) disable iff (srst)
    (loopMode && traceWr_d.valid && !cClear && busEv.kind == TCF_EV_SRC) ##1 (busEv.valid && busEv.kind == TCF_EV_SRC
      && busEv.addr == $past(busEv.addr)) |-> cHit;
  endproperty
  a_loop_load: assert property (p_loop_load) else $error("C not loaded with stored address");

  property p_order;
    @(posedge clk_sys) disable iff (srst)
    traceWr_d.valid |=> traceWr.valid && traceWr.kind == $past(busEv.kind);
  endproperty
  a_order: assert property (p_order) else $error("trace write out of order");

  c_loop_supp: cover property (@(posedge clk_sys) disable iff (srst) supp_q != supp_d);
  c_norm_trig: cover property (@(posedge clk_sys) disable iff (srst) triggered_d && !triggered_q);
  c_loop_store: cover property (@(posedge clk_sys) disable iff (srst) loopMode && traceWr.valid);
  c_other: cover property (@(posedge clk_sys) disable iff (srst) oth_q != oth_d);
endmodule

// ===== pkg/tcf_map.svh
`ifndef TCF_MAP_SVH
`define TCF_MAP_SVH
// ----------------------------------------------------------------
// capture mode encodings
// ----------------------------------------------------------------
`define TCF_MODE_NORMAL 2'h0
`define TCF_MODE_LOOP 2'h1
`define TCF_MODE_DETAIL 2'h2
`define TCF_MODE_PROFILE 2'h3
// ----------------------------------------------------------------
// trigger-mode field encodings
// ----------------------------------------------------------------
`define TCF_TRG_FLOW 1'h0
`define TCF_TRG_DATA 1'h1
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TCF_ADDR_RST 16'h0000
`define TCF_CNT_RST 16'h0000
`endif

// ===== pkg/tcf_pkg.sv
package tcf_pkg;
  // kind of bus event offered for capture
  typedef enum logic [1:0] {
    TCF_EV_SRC = 2'h0,
    TCF_EV_DST = 2'h1,
    TCF_EV_VEC = 2'h2,
    TCF_EV_DATA = 2'h3
  } tcf_ev_t;
  // one observed bus event
  typedef struct packed {
    logic valid;
    tcf_ev_t kind;
    logic [15:0] addr;
    logic [15:0] data;
  } tcf_bus_ev_t;
  // one entry written to the trace buffer
  typedef struct packed {
    logic valid;
    tcf_ev_t kind;
    logic [15:0] word;
  } tcf_trace_wr_t;
endpackage

// ===== rtl/tcf_addr_cmp.sv
`timescale 1ns/1ns
`include "tcf_map.svh"
module tcf_addr_cmp #(
  parameter int AW = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // load and clear
  input wire logic load,
  input wire logic [AW-1:0] loadAddr,
  input wire logic clear,
  // compare
  input wire logic [AW-1:0] probe,
  output logic valid,
  output logic hit
);
  logic [AW-1:0] ref_q;
  logic [AW-1:0] ref_d;
  logic valid_q;
  logic valid_d;

  // refuse widths the compare cannot serve
  if (AW < 1)
  begin : g_aw_check
    $error("tcf_addr_cmp: AW must be positive");
  end

  // next value of the compare reference
  always_comb
  begin
    ref_d = ref_q;
    valid_d = valid_q;
    if (clear)
    begin
      ref_d = '0;
      valid_d = 1'b0;
    end
    else if (load)
    begin
      ref_d = loadAddr;
      valid_d = 1'b1;
    end
  end

  // reference register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ref_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      ref_q <= ref_d;
      valid_q <= valid_d;
    end
  end

  assign valid = valid_q;
  assign hit = valid_q && (probe == ref_q);
endmodule

// ===== rtl/tcf_trig_cmp.sv
`timescale 1ns/1ns
module tcf_trig_cmp #(
  parameter int AW = 16
) (
  // compare values
  input wire logic enable,
  input wire logic [AW-1:0] ref0,
  input wire logic [AW-1:0] ref1,
  input wire logic [AW-1:0] probe,
  // match results
  output logic [1:0] hit
);
  // one equality comparator per trigger channel
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      assign hit[gi] = enable && (probe == (gi == 0 ? ref0 : ref1));
    end
  endgenerate
endmodule

// ===== test/tcf_bus_model.sv
`timescale 1ns/1ns
module tcf_bus_model (
  // clock
  input wire logic clk_sys,
  // bus activity offered to the capture logic
  output tcf_pkg::tcf_bus_ev_t busEv,
  output logic [7:0] busPage
);
  import tcf_pkg::*;
  // -------------------------------------------------
  // processor bus stand-in
  // -------------------------------------------------
  // one event per cycle, launched just after the falling edge
  task automatic send(input tcf_ev_t kind, input logic [15:0] addr, input logic [15:0] data,
                      input logic [7:0] page);
    @(negedge clk_sys);
    busEv = '{valid: 1'b1, kind: kind, addr: addr, data: data};
    busPage = page;
  endtask
  // idle bus shows no stale copy of the last event
  task automatic idle();
    @(negedge clk_sys);
    busEv = '{valid: 1'b0, kind: busEv.kind, addr: ~busEv.addr, data: ~busEv.data};
    busPage = ~busPage;
  endtask
  // quiet bus at time zero
  initial
  begin
    busEv = '{valid: 1'b0, kind: TCF_EV_SRC, addr: 16'h0000, data: 16'h0000};
    busPage = 8'h00;
  end
endmodule

// ===== test/test_trace_capture_loop_filter.sv
`timescale 1ns/1ns
`include "tcf_map.svh"
module test_trace_capture_loop_filter;
  import tcf_pkg::*;
  // -------------------------------------------------
  // stimulus and observation
  // -------------------------------------------------
  logic clk_sys;
  logic srst;
  logic debugEnable;
  logic arm;
  logic [1:0] captureMode;
  logic triggerModeField;
  logic [15:0] cmpA;
  logic [15:0] cmpB;
  logic cmpCBreakEnable;
  logic [15:0] cmpCUser;
  tcf_bus_ev_t busEv;
  logic [7:0] busPage;
  tcf_trace_wr_t traceWr;
  logic triggered;
  logic cmpCBreak;
  logic [15:0] suppressCount;
  logic [15:0] otherModeCount;
  int err_total;
  int tests_run;
  int cyc;
  int brk;
  logic [15:0] gotQ[$];
  logic [15:0] expQ[$];

  tcf_bus_model tcf_bus_model_inst (.clk_sys(clk_sys), .busEv(busEv), .busPage(busPage));
  tcf_capture tcf_capture_inst (
    .clk_sys(clk_sys), .srst(srst), .debugEnable(debugEnable), .arm(arm), .captureMode(captureMode),
    .triggerModeField(triggerModeField), .cmpA(cmpA), .cmpB(cmpB), .cmpCBreakEnable(cmpCBreakEnable),
    .cmpCUser(cmpCUser), .busEv(busEv), .busPage(busPage), .traceWr(traceWr), .triggered(triggered),
    .cmpCBreak(cmpCBreak), .suppressCount(suppressCount), .otherModeCount(otherModeCount)
  );

  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // collect stored words and breakpoint pulses mid-cycle, bound the run
  always @(negedge clk_sys)
  begin
    if (traceWr.valid === 1'b1) gotQ.push_back(traceWr.word);
    if (cmpCBreak === 1'b1) brk++;
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      complete_run();
    end
  end

  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // compare collected trace words against the expected list
  task automatic checkQ();
    repeat (3) @(negedge clk_sys);
    chk(gotQ.size(), expQ.size());
    for (int i = 0; i < expQ.size() && i < gotQ.size(); i++) chk(gotQ[i], expQ[i]);
    gotQ.delete();
    expQ.delete();
  endtask
  // rising arm with mode set up; returns one cycle before events are taken
  task automatic armUp(input logic [1:0] m, input logic t);
    @(negedge clk_sys);
    arm = 1'b0;
    captureMode = m;
    triggerModeField = t;
    @(negedge clk_sys);
    arm = 1'b1;
    @(negedge clk_sys);
  endtask
  // verdict
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // -------------------------------------------------
  // test sequence
  // -------------------------------------------------
  initial
  begin
    srst = 1'b1;
    debugEnable = 1'b1;
    arm = 1'b0;
    captureMode = `TCF_MODE_NORMAL;
    triggerModeField = `TCF_TRG_FLOW;
    cmpA = 16'h1000;
    cmpB = 16'h2000;
    cmpCBreakEnable = 1'b1;
    cmpCUser = 16'h0800;
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    // debug mode off: nothing captured
    debugEnable = 1'b0;
    armUp(`TCF_MODE_LOOP, `TCF_TRG_FLOW);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h0900, 16'h0000, 8'h00);
    tcf_bus_model_inst.idle();
    checkQ();
    debugEnable = 1'b1;
    $display("test debug_off done");
    // loop filter: repeated source suppressed, destinations and vectors kept
    armUp(`TCF_MODE_LOOP, `TCF_TRG_FLOW);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h0100, 16'h0000, 8'h01);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h0100, 16'h0000, 8'h3C);
    tcf_bus_model_inst.send(TCF_EV_DST, 16'h0200, 16'h0000, 8'h00);
    tcf_bus_model_inst.send(TCF_EV_DST, 16'h0200, 16'h0000, 8'h00);
    tcf_bus_model_inst.send(TCF_EV_VEC, 16'hFFFE, 16'h0000, 8'h00);
    tcf_bus_model_inst.send(TCF_EV_VEC, 16'hFFFE, 16'h0000, 8'h00);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h0300, 16'h0000, 8'h00);
    tcf_bus_model_inst.idle();
    expQ = '{16'h0100, 16'h0200, 16'h0200, 16'hFFFE, 16'hFFFE, 16'h0300};
    checkQ();
    chk(suppressCount, 16'h0001);
    $display("test loop_filter done");
    // re-arm clears the reloaded comparator
    armUp(`TCF_MODE_LOOP, `TCF_TRG_FLOW);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h0300, 16'h0000, 8'h00);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h0300, 16'h0000, 8'h00);
    tcf_bus_model_inst.idle();
    expQ = '{16'h0300};
    checkQ();
    chk(suppressCount, 16'h0002);
    chk(brk, 0);
    $display("test loop_rearm done");
    // normal flow capture triggered by comparator A
    armUp(`TCF_MODE_NORMAL, `TCF_TRG_FLOW);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h0500, 16'h0000, 8'h00);
    tcf_bus_model_inst.idle();
    checkQ();
    chk(triggered, 1'b0);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h1000, 16'h0000, 8'h00);
    tcf_bus_model_inst.idle();
    repeat (3) @(negedge clk_sys);
    chk(triggered, 1'b1);
    gotQ.delete();
    tcf_bus_model_inst.send(TCF_EV_DST, 16'h0600, 16'h0000, 8'h00);
    tcf_bus_model_inst.send(TCF_EV_DATA, 16'h0700, 16'hABCD, 8'h00);
    tcf_bus_model_inst.send(TCF_EV_DST, 16'h0800, 16'h0000, 8'h00);
    tcf_bus_model_inst.idle();
    expQ = '{16'h0600, 16'h0800};
    checkQ();
    chk(brk, 1);
    $display("test normal_flow done");
    // normal data capture triggered by comparator B
    armUp(`TCF_MODE_NORMAL, `TCF_TRG_DATA);
    chk(triggered, 1'b0);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h2000, 16'h0000, 8'h00);
    tcf_bus_model_inst.idle();
    repeat (3) @(negedge clk_sys);
    chk(triggered, 1'b1);
    gotQ.delete();
    tcf_bus_model_inst.send(TCF_EV_DATA, 16'h3000, 16'h5A5A, 8'h00);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h0700, 16'h0000, 8'h00);
    tcf_bus_model_inst.idle();
    expQ = '{16'h5A5A};
    checkQ();
    $display("test normal_data done");
    // other two modes: counted only, comparator C may break
    armUp(`TCF_MODE_DETAIL, `TCF_TRG_FLOW);
    tcf_bus_model_inst.send(TCF_EV_SRC, 16'h0800, 16'h0000, 8'h00);
    tcf_bus_model_inst.send(TCF_EV_DST, 16'h0801, 16'h0000, 8'h00);
    tcf_bus_model_inst.idle();
    checkQ();
    chk(brk, 2);
    armUp(`TCF_MODE_PROFILE, `TCF_TRG_FLOW);
    tcf_bus_model_inst.send(TCF_EV_DST, 16'h0900, 16'h0000, 8'h00);
    tcf_bus_model_inst.idle();
    checkQ();
    chk(otherModeCount, 16'h0003);
    $display("test other_modes done");
    complete_run();
  end
endmodule
